/* File: rtl/fmb_host.sv */
/*
 Host controller for the fast memory bus: runs one strobe cycle per request
 (read, write or refresh) and returns read data with the parity fault flag.
 Assumes a single 10 MHz clock; the board's returned lines are asynchronous.
*/
`timescale 1ns/1ns
`default_nettype none
module fmb_host (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire fmb_pkg::fmb_req_s req,
  output logic req_ready,
  output logic rsp_valid,
  output fmb_pkg::fmb_rsp_s rsp,
  output logic cycle_strobe_n,
  output logic write_select_n,
  output logic longword_select_n,
  output logic upper_lane_strobe_n,
  output logic lower_lane_strobe_n,
  output logic refresh_request_n,
  output logic bus_origin_select_n,
  output logic [fmb_pkg::ADDR_W-1:0] fast_addr,
  input wire logic [fmb_pkg::DATA_W-1:0] fast_data_in,
  output logic [fmb_pkg::DATA_W-1:0] fast_data_out,
  output logic fast_data_oe,
  input wire logic parity_fault_n
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    fmb_pkg::fmb_state_e state;
    logic [3:0] cnt;
    fmb_pkg::fmb_req_s cur;
    logic req_ready;
    logic rsp_valid;
    fmb_pkg::fmb_rsp_s rsp;
    logic cyc_n;
    logic wr_n;
    logic lw_n;
    logic ul_n;
    logic ll_n;
    logic ref_n;
    logic org_n;
    logic [fmb_pkg::ADDR_W-1:0] addr;
    logic [fmb_pkg::DATA_W-1:0] dout;
    logic oe;
  } fmb_host_s;

  fmb_host_s st_r;
  fmb_host_s st_nxt;
  logic [fmb_pkg::DATA_W-1:0] rdata_sync;
  logic fault_n_sync;

  // Board lines are asynchronous to clk
  fmb_sync #(.W(fmb_pkg::DATA_W + 1)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({fast_data_in, parity_fault_n}),
    .q({rdata_sync, fault_n_sync})
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp_valid = 1'b0;
    st_nxt.cnt = st_r.cnt + fmb_pkg::CNT_ONE;
    case (st_r.state)
      fmb_pkg::FMB_IDLE: begin
        st_nxt.req_ready = 1'b1;
        if (req_valid && st_r.req_ready) begin
          st_nxt.req_ready = 1'b0;
          st_nxt.cur = req;
          st_nxt.cnt = '0;
          st_nxt.state = fmb_pkg::FMB_SETUP;
          // Qualifiers and address set up ahead of the strobe
          st_nxt.wr_n = ~req.write;
          st_nxt.lw_n = ~req.longword;
          st_nxt.ref_n = ~req.refresh;
          st_nxt.org_n = ~req.from_system_bus;
          st_nxt.addr = req.addr;
          // Early mode presents lanes with the qualifiers
          st_nxt.ul_n = req.late_strobe_mode | ~req.upper_lane;
          st_nxt.ll_n = req.late_strobe_mode | ~req.lower_lane;
        end
      end
      fmb_pkg::FMB_SETUP: begin
        if (st_r.cnt == 4'(fmb_pkg::SETUP_CYC - 1)) begin
          st_nxt.cnt = '0;
          st_nxt.state = fmb_pkg::FMB_ACTIVE;
          st_nxt.cyc_n = 1'b0;
          // Late mode: lanes with assertion, well inside 45ns
          st_nxt.ul_n = ~st_r.cur.upper_lane;
          st_nxt.ll_n = ~st_r.cur.lower_lane;
          // Write data driven at assertion
          if (st_r.cur.write && !st_r.cur.refresh) begin
            st_nxt.dout = st_r.cur.wdata;
            st_nxt.oe = 1'b1;
          end
        end
      end
      fmb_pkg::FMB_ACTIVE: begin
        // Write data held at least 95ns from assertion
        if (st_r.cnt == 4'(fmb_pkg::WHOLD_CYC)) begin
          st_nxt.oe = st_r.cur.write ? st_r.oe : 1'b0;
        end
        // Strobe held past 120ns and until returned lines sampled
        if (st_r.cnt == 4'(fmb_pkg::ACTIVE_CYC - 1)) begin
          st_nxt.cnt = '0;
          st_nxt.state = fmb_pkg::FMB_RECOVER;
          st_nxt.cyc_n = 1'b1;
          st_nxt.oe = 1'b0;
          st_nxt.rsp_valid = 1'b1;
          // Read data and fault sampled while still held by the board
          st_nxt.rsp.rdata = (st_r.cur.write || st_r.cur.refresh) ? '0 : rdata_sync;
          // Undriven fault line out of window reads as no fault
          st_nxt.rsp.parity_fault =
              ~st_r.cur.write & ~st_r.cur.refresh & ~fault_n_sync;
        end
      end
      fmb_pkg::FMB_RECOVER: begin
        // Row precharge recovery before the next cycle
        if (st_r.cnt == 4'(fmb_pkg::RECOVER_CYC - 1)) begin
          st_nxt.state = fmb_pkg::FMB_IDLE;
          st_nxt.req_ready = 1'b1;
          st_nxt.wr_n = 1'b1;
          st_nxt.lw_n = 1'b1;
          st_nxt.ul_n = 1'b1;
          st_nxt.ll_n = 1'b1;
          st_nxt.ref_n = 1'b1;
          st_nxt.org_n = 1'b1;
        end
      end
      default: begin
        st_nxt.state = fmb_pkg::FMB_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // Every phase runs on the four-bit counter and must end before it wraps
  if (fmb_pkg::SETUP_CYC < 1 || fmb_pkg::SETUP_CYC > 15) begin : g_bad_setup
    $error("fmb_host: setup phase does not fit the phase counter");
  end
  if (fmb_pkg::ACTIVE_CYC < 1 || fmb_pkg::ACTIVE_CYC > 15) begin : g_bad_active
    $error("fmb_host: active phase does not fit the phase counter");
  end
  if (fmb_pkg::RECOVER_CYC < 1 || fmb_pkg::RECOVER_CYC > 15) begin : g_bad_recover
    $error("fmb_host: recovery phase does not fit the phase counter");
  end
  // Qualifiers lead the strobe by whole setup cycles
  if (fmb_pkg::SETUP_CYC * fmb_pkg::CLK_PERIOD_NS < fmb_pkg::T_SETUP_NS) begin : g_bad_lead
    $error("fmb_host: setup phase shorter than qualifier lead time");
  end
  // Strobe low and high times
  if (fmb_pkg::ACTIVE_CYC * fmb_pkg::CLK_PERIOD_NS < fmb_pkg::T_STROBE_MIN_NS) begin : g_bad_low
    $error("fmb_host: strobe active phase too short");
  end
  if (fmb_pkg::RECOVER_CYC * fmb_pkg::CLK_PERIOD_NS < fmb_pkg::T_RECOVER_NS) begin : g_bad_high
    $error("fmb_host: recovery phase too short");
  end
  // Write data stays driven until the strobe is released
  if (fmb_pkg::ACTIVE_CYC * fmb_pkg::CLK_PERIOD_NS < fmb_pkg::T_WDATA_HOLD_NS) begin : g_bad_whold
    $error("fmb_host: write data released too early");
  end
  // First sync stage must sample after the board's latest valid time
  if (fmb_pkg::ACTIVE_CYC <= fmb_pkg::SYNC_CYC ||
      (fmb_pkg::ACTIVE_CYC - fmb_pkg::SYNC_CYC) * fmb_pkg::CLK_PERIOD_NS < fmb_pkg::T_PARITY_NS ||
      (fmb_pkg::ACTIVE_CYC - fmb_pkg::SYNC_CYC) * fmb_pkg::CLK_PERIOD_NS < fmb_pkg::T_ACCESS_NS
  ) begin : g_bad_sample
    $error("fmb_host: returned lines sampled before they settle");
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.cyc_n <= 1'b1;
      st_r.wr_n <= 1'b1;
      st_r.lw_n <= 1'b1;
      st_r.ul_n <= 1'b1;
      st_r.ll_n <= 1'b1;
      st_r.ref_n <= 1'b1;
      st_r.org_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------------
  assign req_ready = st_r.req_ready;
  assign rsp_valid = st_r.rsp_valid;
  assign rsp = st_r.rsp;
  assign cycle_strobe_n = st_r.cyc_n;
  assign write_select_n = st_r.wr_n;
  assign longword_select_n = st_r.lw_n;
  assign upper_lane_strobe_n = st_r.ul_n;
  assign lower_lane_strobe_n = st_r.ll_n;
  assign refresh_request_n = st_r.ref_n;
  assign bus_origin_select_n = st_r.org_n;
  assign fast_addr = st_r.addr;
  assign fast_data_out = st_r.dout;
  assign fast_data_oe = st_r.oe;

endmodule
`default_nettype wire

/* File: rtl/fmb_pkg.sv */
/*
 Package for the fast memory bus host controller: timing constants, cycle
 request and answer structs, state encoding.
 Assumes a 10 MHz core clock (100 ns period).
*/
package fmb_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned T_ACCESS_NS = 125;      // Read data valid after strobe
  localparam int unsigned T_CYCLE_NS = 210;       // Whole cycle incl. recovery
  localparam int unsigned T_STROBE_MIN_NS = 120;  // Strobe active least
  localparam int unsigned T_RECOVER_NS = 90;      // Strobe inactive least
  localparam int unsigned T_SETUP_NS = 30;        // Qualifiers before strobe
  localparam int unsigned T_LATE_LANE_NS = 45;    // Late lane strobes after strobe
  localparam int unsigned T_PARITY_NS = 135;      // Parity fault valid after strobe
  localparam int unsigned T_WDATA_HOLD_NS = 95;   // Write data hold from strobe

  // Least times round up
  localparam int unsigned SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WHOLD_CYC = (T_WDATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Sampling must wait for the latest valid time, so these also round up
  localparam int unsigned PARITY_CYC = (T_PARITY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RDATA_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_CYC_MIN =
      (T_STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Strobe held for the longer of parity fault settling and least strobe time, plus sync delay
  localparam int unsigned SYNC_CYC = 2;
  localparam int unsigned ACTIVE_CYC =
      ((PARITY_CYC > STROBE_CYC_MIN) ? PARITY_CYC : STROBE_CYC_MIN) + SYNC_CYC;

  localparam int unsigned ADDR_W = 27;  // Word address bits 27..1
  localparam int unsigned DATA_W = 32;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic write;
    logic longword;
    logic upper_lane;
    logic lower_lane;
    logic refresh;
    logic from_system_bus;
    logic late_strobe_mode;
  } fmb_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic parity_fault;
  } fmb_rsp_s;

  typedef enum logic [2:0] {
    FMB_IDLE = 3'b000,
    FMB_SETUP = 3'b001,
    FMB_ACTIVE = 3'b011,
    FMB_RECOVER = 3'b010
  } fmb_state_e;

endpackage

/* File: rtl/fmb_sync.sv */
/*
 Two flip-flop synchroniser, one per bit.
 Assumes inputs arrive from outside the clk domain.
*/
`timescale 1ns/1ns
`default_nettype none
module fmb_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } fmb_sync_s;

  fmb_sync_s st_r;
  fmb_sync_s st_nxt;

  always_comb begin
    st_nxt.meta = d;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.stable;

endmodule
`default_nettype wire

/* File: sim/fmb_board_model.sv */
/* Memory board model with byte parity behind the strobe bus.
 Assumes the bench sets bad_parity and slow between cycles. */
`timescale 1ns/1ns
`default_nettype none
module fmb_board_model #(
  parameter logic [5:0] WIN_TAG = 6'h00
) (
  input wire logic cycle_strobe_n,
  input wire logic write_select_n,
  input wire logic longword_select_n,
  input wire logic upper_lane_strobe_n,
  input wire logic lower_lane_strobe_n,
  input wire logic refresh_request_n,
  input wire logic bus_origin_select_n,
  input wire logic [26:0] fast_addr,
  input wire logic [31:0] fast_data_out,
  input wire logic bad_parity,
  input wire logic slow,
  output logic [31:0] fast_data_in,
  output logic parity_fault_n,
  output logic sys_ack_n
);
  logic [35:0] mem [logic [25:0]];
  logic [35:0] w;
  logic [3:0] be;
  logic up, lo, fault;
  initial begin
    fast_data_in = 32'h5555_aaaa;
    parity_fault_n = 1'b1;
    sys_ack_n = 1'b1;
  end
  // System-bus acknowledge; no system data strobes here, so it holds to the next cycle
  always @(negedge cycle_strobe_n) begin
    sys_ack_n = 1'b1;
    if (!bus_origin_select_n && refresh_request_n && fast_addr[26:21] == WIN_TAG) begin
      #(write_select_n ? 160 : 40) sys_ack_n = 1'b0;
    end
  end
  always @(negedge cycle_strobe_n) begin
    if (refresh_request_n && fast_addr[26:21] == WIN_TAG) begin
      // Fresh longwords carry bad parity until written
      w = mem.exists(fast_addr[26:1]) ? mem[fast_addr[26:1]] : 36'hf_0000_0000;
      if (!write_select_n) begin
        #50;
        up = !upper_lane_strobe_n;
        lo = !lower_lane_strobe_n;
        be = !longword_select_n ? {up, up, lo, lo} : fast_addr[0] ? {2'h0, up, lo} : {up, lo, 2'h0};
        for (int b = 0; b < 4; b++) begin
          if (be[b]) begin
            w[8*b+:8] = fast_data_out[8*b+:8];
            w[32+b] = ^fast_data_out[8*b+:8] ^ bad_parity;
          end
        end
        mem[fast_addr[26:1]] = w;
      end else begin
        #(slow ? 120 : 60);
        fault = 1'b0;
        for (int b = 0; b < 4; b++) begin
          fault = fault | ((^w[8*b+:8]) != w[32+b]);
        end
        fast_data_in = w[31:0];
        parity_fault_n = !fault;
        @(posedge cycle_strobe_n);
        // Released lines must not keep the old value
        #40 fast_data_in = ~fast_data_in;
        #10 parity_fault_n = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/fmb_host_sva.sv */
/* Checker for the fmb_host strobe bus.
 Assumes one 100 ns clock; bound from the bench top file. */
`timescale 1ns/1ns
`default_nettype none
module fmb_host_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire fmb_pkg::fmb_req_s req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic cycle_strobe_n,
  input wire logic write_select_n,
  input wire logic upper_lane_strobe_n,
  input wire logic lower_lane_strobe_n,
  input wire logic refresh_request_n,
  input wire logic [fmb_pkg::ADDR_W-1:0] fast_addr,
  input wire logic [fmb_pkg::DATA_W-1:0] fast_data_out,
  input wire logic fast_data_oe
);
  fmb_pkg::fmb_req_s req_r;
  logic [1:0] lanes_n;
  assign lanes_n = {upper_lane_strobe_n, lower_lane_strobe_n};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_r <= '0;
    end else if (req_valid && req_ready) begin
      req_r <= req;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_take; req_valid && req_ready; endsequence
  sequence s_low; !cycle_strobe_n [*4]; endsequence
  sequence s_done; cycle_strobe_n && rsp_valid; endsequence
  a_cycle_shape: assert property (s_take |=> cycle_strobe_n ##1 s_low ##1 s_done)
    else $error("strobe cycle shape wrong");
  a_recover_gap: assert property ($rose(cycle_strobe_n) |=> cycle_strobe_n)
    else $error("recovery too short");
  a_qual_setup: assert property ($fell(cycle_strobe_n) |-> fast_addr == req_r.addr &&
    write_select_n == !req_r.write && $stable({fast_addr, write_select_n, refresh_request_n}))
    else $error("qualifiers not set up");
  a_qual_hold: assert property (!cycle_strobe_n && !$past(cycle_strobe_n) |->
    $stable({fast_addr, write_select_n, refresh_request_n, lanes_n})) else $error("moved in strobe");
  a_early_lanes: assert property ($fell(cycle_strobe_n) && !req_r.late_strobe_mode |->
    $stable(lanes_n)) else $error("early lanes late");
  a_lane_value: assert property ($fell(cycle_strobe_n) && refresh_request_n |->
    lanes_n == ~{req_r.upper_lane, req_r.lower_lane}) else $error("lane strobes wrong");
  a_wdata_hold: assert property ($fell(cycle_strobe_n) && !write_select_n && refresh_request_n
    |-> fast_data_oe && fast_data_out == req_r.wdata ##1 fast_data_oe && $stable(fast_data_out))
    else $error("write data not held");
  a_oe_window: assert property (fast_data_oe |-> !write_select_n && !cycle_strobe_n)
    else $error("data driven outside write");
  a_ready_gap: assert property (s_take |=> !req_ready [*6] ##1 req_ready)
    else $error("ready not held low through cycle");
endmodule
`default_nettype wire

/* File: sim/fmb_host_tb.sv */
/* Bench for fmb_host against the board model.
 Assumes package, checker and model compiled first. */
`timescale 1ns/1ns
`default_nettype none
module fmb_host_tb;
  logic clk, rst_b, req_valid, req_ready, rsp_valid, bad_parity, slow, fast_data_oe;
  logic cycle_strobe_n, write_select_n, longword_select_n, upper_lane_strobe_n;
  logic lower_lane_strobe_n, refresh_request_n, bus_origin_select_n, parity_fault_n, sys_ack_n;
  logic [26:0] fast_addr;
  logic [31:0] fast_data_in, fast_data_out;
  fmb_pkg::fmb_req_s req;
  fmb_pkg::fmb_rsp_s rsp;
  logic [31:0] shd [int];
  logic [3:0] badb [int];
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  fmb_host DUT (.clk, .rst_b, .req_valid, .req, .req_ready, .rsp_valid, .rsp, .cycle_strobe_n,
    .write_select_n, .longword_select_n, .upper_lane_strobe_n, .lower_lane_strobe_n,
    .refresh_request_n, .bus_origin_select_n, .fast_addr, .fast_data_in, .fast_data_out,
    .fast_data_oe, .parity_fault_n);
  fmb_board_model u_board (.cycle_strobe_n, .write_select_n, .longword_select_n,
    .upper_lane_strobe_n, .lower_lane_strobe_n, .refresh_request_n, .fast_addr,
    .fast_data_out, .bad_parity, .slow, .fast_data_in, .parity_fault_n, .bus_origin_select_n,
    .sys_ack_n);
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // f holds write, longword, upper, lower, refresh, late
  task automatic op(input logic [26:0] a, input logic [31:0] d, input logic [5:0] f);
    int n;
    int k;
    logic [3:0] be;
    n = 0;
    k = int'(a[26:1]);
    req = '{a, d, f[5], f[4], f[3], f[2], f[1], 1'($urandom), f[0]};
    while (req_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("rsp_valid", 33'(rsp_valid), 33'h0_0000_0001);
    chk("sys_ack", 33'(sys_ack_n), 33'(!(req.from_system_bus && !f[1] && !a[26])));
    be = f[4] ? {f[3], f[3], f[2], f[2]} : a[0] ? {2'h0, f[3], f[2]} : {f[3], f[2], 2'h0};
    if (f[5] || f[1]) begin
      chk("write_rsp", rsp, 33'h0_0000_0000);
      if (f[5] && !f[1] && !a[26] && !shd.exists(k)) begin
        shd[k] = 32'h0000_0000;
        badb[k] = 4'hf;
      end
      for (int b = 0; b < 4; b++) begin
        if (f[5] && !f[1] && !a[26] && be[b]) begin
          shd[k][8*b+:8] = d[8*b+:8];
          badb[k][b] = bad_parity;
        end
      end
    end else if (a[26]) begin
      chk("outside_fault", 33'(rsp.parity_fault), 33'h0_0000_0000);
    end else if (!shd.exists(k)) begin
      chk("blank_fault", 33'(rsp.parity_fault), 33'h0_0000_0001);
    end else begin
      chk("read_rsp", rsp, {shd[k], |badb[k]});
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      stop_test;
    end
  end
  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req = '0;
    bad_parity = 1'b0;
    slow = 1'b0;
    void'($urandom(99));
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    for (int i = 0; i < 4; i++) op(27'(2 * i), $urandom, 6'h3c | 6'(i % 2));
    for (int i = 0; i < 40; i++) begin
      slow = 1'($urandom);
      op(27'($urandom_range(7)), $urandom, 6'($urandom) & 6'h3d);
    end
    op(27'h000_0000, 32'hffff_ffff, 6'h3e);
    op(27'h000_0000, 32'h0000_0000, 6'h1c);
    op(27'h000_0021, 32'h0000_0000, 6'h1c);
    bad_parity = 1'b1;
    op(27'h000_0002, 32'hffff_0000, 6'h2c);
    bad_parity = 1'b0;
    op(27'h000_0002, 32'h0000_0000, 6'h1d);
    op(27'h400_0002, 32'h0000_0000, 6'h1c);
    stop_test;
  end
endmodule
bind fmb_host fmb_host_sva u_sva (.clk, .rst_b, .req_valid, .req, .req_ready, .rsp_valid,
  .cycle_strobe_n, .write_select_n, .upper_lane_strobe_n, .lower_lane_strobe_n,
  .refresh_request_n, .fast_addr, .fast_data_out, .fast_data_oe);
`default_nettype wire
